/* core/msc_pkg.sv */
// Package for module stop and mode control: map, resets, modes, carriers
package msc_pkg;
    localparam logic [3:0] ADR_MAIN_HI  = 4'h0;
    localparam logic [3:0] ADR_MAIN_LO  = 4'h4;
    localparam logic [3:0] ADR_SUB_HI   = 4'h8;
    localparam logic [3:0] ADR_SUB_LO   = 4'hC;
    localparam logic [3:0] ADR_MODE_CFG = 4'h0;
    localparam logic [3:0] ADR_STATUS   = 4'h4;
    localparam logic [1:0] PAGE_STOP    = 2'h0;
    localparam logic [1:0] PAGE_MODE    = 2'h1;

    localparam logic [7:0] RST_MAIN_HI = 8'h3F;
    localparam logic [7:0] RST_MAIN_LO = 8'hFF;
    localparam logic [7:0] RST_SUB_HI  = 8'hFF;
    localparam logic [7:0] RST_SUB_LO  = 8'hFF;
    // Bits that must read and stay as fixed values
    localparam logic [7:0] FIX0_MAIN_HI = 8'h80;
    localparam logic [7:0] FIX1_MAIN_LO = 8'h05;
    localparam logic [7:0] FIX1_SUB_HI  = 8'hFC;
    localparam logic [7:0] FIX1_SUB_LO  = 8'hBD;

    localparam int MH_XFER = 6;
    localparam int MH_FRT  = 5;
    localparam int MH_TMRA = 4;
    localparam int MH_PWM  = 3;
    localparam int MH_DAC  = 2;
    localparam int MH_ADC  = 1;
    localparam int MH_TMRB = 0;
    localparam int ML_SER0 = 7;
    localparam int ML_SER1 = 6;
    localparam int ML_SER2 = 5;
    localparam int ML_I2C0 = 4;
    localparam int ML_I2C1 = 3;
    localparam int ML_CRC  = 1;
    localparam int SH_GF   = 1;
    localparam int SH_DES  = 0;
    localparam int SL_CARD = 6;
    localparam int SL_USB  = 1;
    localparam int NUM_PERIPH = 16;

    // Mode configuration field positions
    localparam int CFG_SBY   = 0;
    localparam int CFG_LSON  = 1;
    localparam int CFG_WDSUB = 2;

    typedef enum logic [3:0] {
        MSC_RESET, MSC_HIGH, MSC_MEDIUM, MSC_SUBACT, MSC_SLEEP,
        MSC_WATCH, MSC_SUBSLP, MSC_SWSBY, MSC_HWSBY
    } msc_mode_e;

    typedef struct packed {
        logic main_clk_run;
        logic sub_clk_run;
        logic cpu_run;
        logic cpu_on_sub;
        logic cpu_regs_keep;
        logic ext_irq_en;
        logic wdt_run;
        logic wdt_on_sub;
        logic wdt_clear;
    } msc_state_s;

    typedef struct packed {
        logic [7:0] main_hi;
        logic [7:0] main_lo;
        logic [7:0] sub_hi;
        logic [7:0] sub_lo;
    } msc_stop_s;
endpackage

/* core/msc_mode_dec.sv */
// Decoder from operating mode to clock and unit run states
`timescale 1ns/1ps
module msc_mode_dec
    import msc_pkg::*;
(
    input  wire msc_mode_e  mode,
    output msc_state_s      st
);
    always_comb begin
        st = '0;
        unique case (mode)
            MSC_HIGH, MSC_MEDIUM: begin
                st = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0,
                       1'b0};  // see RL12 see RL13
            end
            MSC_SLEEP: begin
                st = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0,
                       1'b0};
            end
            MSC_WATCH, MSC_SUBSLP: begin
                st = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
                       1'b0};  // see RL14
            end
            MSC_SUBACT: begin
                st = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                       1'b0};
            end
            MSC_SWSBY: begin
                st = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0,
                       1'b0};
            end
            MSC_HWSBY: begin
                st = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                       1'b1};
            end
            MSC_RESET: begin
                st = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                       1'b1};
            end
        endcase
    end
endmodule

/* core/msc_stop_regs.sv */
// Module stop registers with fixed-bit protection
`timescale 1ns/1ps
module msc_stop_regs
    import msc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_sel,
    input  wire logic [7:0] wr_data,
    output msc_stop_s       stop
);
    msc_stop_s stop_ff;
    msc_stop_s nxt_stop;

    assign stop = stop_ff;

    // Fixed bits are forced so a stray write cannot break them
    always_comb begin
        nxt_stop = stop_ff;
        if (wr_en) begin
            unique case (wr_sel)
                2'h0: nxt_stop.main_hi = wr_data & ~FIX0_MAIN_HI; // see RL3
                2'h1: nxt_stop.main_lo = wr_data | FIX1_MAIN_LO;  // see RL5
                2'h2: nxt_stop.sub_hi  = wr_data | FIX1_SUB_HI;
                2'h3: nxt_stop.sub_lo  = wr_data | FIX1_SUB_LO;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stop_ff <= '{RST_MAIN_HI, RST_MAIN_LO, RST_SUB_HI,
                         RST_SUB_LO};  // see RL3 see RL4 see RL6 see RL7
        end else begin
            stop_ff <= nxt_stop;
        end
    end

    a_fixed_bits_hold: assert property (@(posedge clk) disable iff (rst)
        ((stop_ff.main_hi & FIX0_MAIN_HI) == 8'h00) &&
        ((stop_ff.sub_lo & FIX1_SUB_LO) == FIX1_SUB_LO)) // see RL5
        else $error("fixed stop bits changed");
endmodule

/* core/msc_top.sv */
// Module stop and operating mode controller, Wishbone slave
// Operation
// RL1: Stop bit one halts its peripheral, zero lets it run; here only main register bits gate PERIPH_CLK_EN.
// RL2: High main register maps bits 6..0 to listed peripherals.
// RL3: High main resets 3F; bit 7 must never be one.
// RL4: Low main resets FF; serial, I2C and CRC mapping.
// RL5: Unassigned bits resetting to one stay one.
// RL6: High sub register resets FF; bit1 GF, bit0 DES.
// RL7: Low sub register resets FF; bit6 card, bit1 USB.
// RL8: Sleep instruction enters the halt mode selected by settings; from sub-active with all three cfg bits set the code stays in sub-active.
// RL9: Accepted interrupt returns halt mode to execution.
// RL10: Standby pin low forces hardware standby from anywhere.
// RL11: Reset pin low forces reset except in hardware standby.
// RL12: Main clock runs only in fast modes; subclock except standbys.
// RL13: CPU halt, subclock run, register and interrupt states per mode.
// RL14: Secondary watchdog on subclock, retained or reset in standbys.
// RL15: Stopped peripheral clock gated, state kept, resumes on clear; only main register units have a clock enable here.
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module msc_top
    import msc_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic [4:0]  WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    output logic             WB_ACK_O,
    input  wire logic        STANDBY_PIN_N,
    input  wire logic        RESET_PIN_N,
    input  wire logic        SLEEP_EXEC,
    input  wire logic        IRQ_ACCEPT,
    input  wire logic        MEDIUM_REQ,
    output logic [15:0]      PERIPH_CLK_EN,
    output logic [3:0]       MODE,
    output logic             MAIN_CLK_RUN,
    output logic             SUB_CLK_RUN,
    output logic             CPU_RUN,
    output logic             CPU_ON_SUB,
    output logic             CPU_REGS_KEEP,
    output logic             EXT_IRQ_EN,
    output logic             WDT_RUN,
    output logic             WDT_ON_SUB,
    output logic             WDT_CLEAR
);
    msc_mode_e   mode_ff, nxt_mode;
    msc_mode_e   run_mode_ff, nxt_run_mode;
    logic [2:0]  cfg_ff, nxt_cfg;
    logic        ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    logic [15:0] clk_en_ff, nxt_clk_en;
    msc_state_s  st_ff, st_comb;
    msc_stop_s   stop;
    logic        stop_wr;
    logic [1:0]  stop_sel;

    function automatic logic is_halt(input msc_mode_e m);
        return m inside {MSC_SLEEP, MSC_WATCH, MSC_SUBSLP, MSC_SWSBY};
    endfunction

    function automatic logic is_exec(input msc_mode_e m);
        return m inside {MSC_HIGH, MSC_MEDIUM, MSC_SUBACT};
    endfunction

    // Request decode; one-cycle ack, dropped after each beat
    wire req = WB_CYC_I && WB_STB_I && !ack_ff;
    // Page on bit 4 only, so bits 3:2 select all four words of a page
    wire [1:0] page = {1'b0, WB_ADR_I[4]};
    wire [3:0] adr4 = {WB_ADR_I[3:2], 2'h0};
    wire stop_hit = req && WB_WE_I && WB_SEL_I[0] && page == PAGE_STOP;

    assign stop_wr  = stop_hit;
    assign stop_sel = WB_ADR_I[3:2];

    msc_stop_regs u_stop (
        .clk     (CLK_SYS),
        .rst     (RST),
        .wr_en   (stop_wr),
        .wr_sel  (stop_sel),
        .wr_data (WB_DAT_I[7:0]),
        .stop    (stop)
    );

    msc_mode_dec u_dec (
        .mode (nxt_mode),
        .st   (st_comb)
    );

    always_comb begin
        nxt_ack  = req;
        nxt_rdat = '0;
        nxt_cfg  = cfg_ff;
        if (req && page == PAGE_MODE && WB_WE_I && WB_SEL_I[0] &&
            adr4 == ADR_MODE_CFG) begin
            nxt_cfg = WB_DAT_I[2:0];
        end
        if (req && !WB_WE_I) begin
            if (page == PAGE_STOP) begin
                unique case (adr4)
                    ADR_MAIN_HI: nxt_rdat[7:0] = stop.main_hi;
                    ADR_MAIN_LO: nxt_rdat[7:0] = stop.main_lo;
                    ADR_SUB_HI:  nxt_rdat[7:0] = stop.sub_hi;
                    ADR_SUB_LO:  nxt_rdat[7:0] = stop.sub_lo;
                endcase
            end else if (page == PAGE_MODE) begin
                if (adr4 == ADR_MODE_CFG) nxt_rdat[2:0] = cfg_ff;
                else if (adr4 == ADR_STATUS) nxt_rdat[3:0] = mode_ff;
            end
        end
    end

    // Mode sequencing: standby pin beats reset pin beats software
    always_comb begin
        nxt_mode     = mode_ff;
        nxt_run_mode = run_mode_ff;
        if (!STANDBY_PIN_N) begin
            nxt_mode = MSC_HWSBY;                         // see RL10
        end else if (mode_ff == MSC_HWSBY) begin
            // Leaving hardware standby always goes through reset
            nxt_mode = MSC_RESET;                         // see RL11
        end else if (!RESET_PIN_N) begin
            nxt_mode = MSC_RESET;                         // see RL11
        end else if (mode_ff == MSC_RESET) begin
            nxt_mode     = MSC_HIGH;
            nxt_run_mode = MSC_HIGH;
        end else if (is_exec(mode_ff) && SLEEP_EXEC) begin
            nxt_run_mode = mode_ff;
            if (!cfg_ff[CFG_SBY]) begin
                nxt_mode = (mode_ff == MSC_SUBACT) ? MSC_SUBSLP : MSC_SLEEP;
            end else if (cfg_ff[CFG_LSON] && cfg_ff[CFG_WDSUB]) begin
                nxt_mode = (mode_ff == MSC_SUBACT) ? MSC_SUBACT : MSC_WATCH;
            end else begin
                nxt_mode = MSC_SWSBY;                     // see RL8
            end
        end else if (is_halt(mode_ff) && IRQ_ACCEPT) begin
            // Watch with subclock selected resumes in sub-active
            nxt_mode = (mode_ff == MSC_WATCH && cfg_ff[CFG_LSON]) ?
                       MSC_SUBACT : run_mode_ff;          // see RL9
        end else if (mode_ff == MSC_HIGH && MEDIUM_REQ) begin
            nxt_mode = MSC_MEDIUM;
        end else if (mode_ff == MSC_MEDIUM && !MEDIUM_REQ) begin
            nxt_mode = MSC_HIGH;
        end
    end

    // Gated clock enables; stopped units keep their own registers
    always_comb begin
        logic [15:0] all;
        all = {stop.main_hi, stop.main_lo};
        nxt_clk_en = '0;
        for (int i = 0; i < NUM_PERIPH; i++) begin
            nxt_clk_en[i] = st_comb.main_clk_run && !all[i];  // see RL1
        end
        nxt_clk_en[15] = st_comb.main_clk_run && !stop.main_hi[MH_XFER]
                         && !stop.main_hi[7];              // see RL15
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            mode_ff     <= MSC_RESET;
            run_mode_ff <= MSC_HIGH;
            cfg_ff      <= '0;
            ack_ff      <= 1'b0;
            rdat_ff     <= '0;
            clk_en_ff   <= '0;
            st_ff       <= '0;
        end else begin
            mode_ff     <= nxt_mode;
            run_mode_ff <= nxt_run_mode;
            cfg_ff      <= nxt_cfg;
            ack_ff      <= nxt_ack;
            rdat_ff     <= nxt_rdat;
            clk_en_ff   <= nxt_clk_en;
            st_ff       <= st_comb;                        // see RL12
        end
    end

    assign WB_ACK_O      = ack_ff;
    assign WB_DAT_O      = rdat_ff;
    assign PERIPH_CLK_EN = clk_en_ff;
    assign MODE          = mode_ff;
    assign MAIN_CLK_RUN  = st_ff.main_clk_run;
    assign SUB_CLK_RUN   = st_ff.sub_clk_run;
    assign CPU_RUN       = st_ff.cpu_run;
    assign CPU_ON_SUB    = st_ff.cpu_on_sub;
    assign CPU_REGS_KEEP = st_ff.cpu_regs_keep;
    assign EXT_IRQ_EN    = st_ff.ext_irq_en;
    assign WDT_RUN       = st_ff.wdt_run;
    assign WDT_ON_SUB    = st_ff.wdt_on_sub;
    assign WDT_CLEAR     = st_ff.wdt_clear;

    sequence s_standby_low;
        !STANDBY_PIN_N;
    endsequence

    a_standby_forces_hw: assert property (@(posedge CLK_SYS) disable iff (RST)
        s_standby_low |=> mode_ff == MSC_HWSBY) // see RL10
        else $error("standby pin did not force hardware standby");

    a_reset_pin_mode: assert property (@(posedge CLK_SYS) disable iff (RST)
        STANDBY_PIN_N && !RESET_PIN_N && mode_ff != MSC_HWSBY
        |=> mode_ff == MSC_RESET) // see RL11
        else $error("reset pin did not force reset");

    a_hw_ignores_reset: assert property (@(posedge CLK_SYS) disable iff (RST)
        !STANDBY_PIN_N ##1 !STANDBY_PIN_N |-> mode_ff == MSC_HWSBY) // see RL11
        else $error("reset pin changed hardware standby");

    a_sleep_enters_halt: assert property (@(posedge CLK_SYS) disable iff (RST)
        STANDBY_PIN_N && RESET_PIN_N && is_exec(mode_ff) && SLEEP_EXEC &&
        mode_ff != MSC_SUBACT |=> is_halt(mode_ff)) // see RL8
        else $error("sleep did not halt");

    a_irq_wakes: assert property (@(posedge CLK_SYS) disable iff (RST)
        STANDBY_PIN_N && RESET_PIN_N && is_halt(mode_ff) && IRQ_ACCEPT
        |=> is_exec(mode_ff)) // see RL9
        else $error("interrupt did not wake");

    a_clock_per_mode: assert property (@(posedge CLK_SYS) disable iff (RST)
        !$past(RST) |-> (MAIN_CLK_RUN == (mode_ff inside {MSC_HIGH, MSC_MEDIUM,
        MSC_SLEEP, MSC_RESET})) && (SUB_CLK_RUN ==
        !(mode_ff inside {MSC_SWSBY, MSC_HWSBY}))) // see RL12
        else $error("clock run state wrong for mode");

    a_cpu_halted: assert property (@(posedge CLK_SYS) disable iff (RST)
        is_halt(mode_ff) |-> !CPU_RUN || $past(mode_ff) != mode_ff) // see RL13
        else $error("cpu runs in halt mode");

    a_wdt_standby: assert property (@(posedge CLK_SYS) disable iff (RST)
        mode_ff == MSC_HWSBY && $past(mode_ff) == MSC_HWSBY
        |-> WDT_CLEAR && !WDT_RUN && !EXT_IRQ_EN) // see RL14
        else $error("watchdog not reset in hardware standby");

    a_stop_gates_clk: assert property (@(posedge CLK_SYS) disable iff (RST)
        stop.main_lo[ML_SER0] ##1 stop.main_lo[ML_SER0]
        |-> !PERIPH_CLK_EN[ML_SER0]) // see RL1
        else $error("stopped peripheral still clocked");
endmodule

/* bench/msc_top_tb.sv */
// Self-checking bench for the module stop and mode controller
`timescale 1ns/1ps
module msc_top_tb;
    import msc_pkg::*;

    logic        CLK_SYS = 1'b0;
    logic        RST = 1'b1;
    logic [4:0]  WB_ADR_I = '0;
    logic [31:0] WB_DAT_I = '0;
    logic [31:0] WB_DAT_O;
    logic        WB_WE_I = 1'b0;
    logic [3:0]  WB_SEL_I = '0;
    logic        WB_CYC_I = 1'b0;
    logic        WB_STB_I = 1'b0;
    logic        WB_ACK_O;
    logic        STANDBY_PIN_N = 1'b1;
    logic        RESET_PIN_N = 1'b1;
    logic        SLEEP_EXEC = 1'b0;
    logic        IRQ_ACCEPT = 1'b0;
    logic        MEDIUM_REQ = 1'b0;
    logic [15:0] PERIPH_CLK_EN;
    logic [3:0]  MODE;
    logic [8:0]  obs;
    logic [15:0] stop16;
    logic [31:0] rd;
    logic [7:0]  wv;
    logic [7:0]  ev;
    integer      seed = 32'h4477;
    int          miscompares = 0;
    int          n_tests = 0;

    always #4 CLK_SYS = ~CLK_SYS;

    msc_top msc_top_inst (
        .CLK_SYS(CLK_SYS), .RST(RST), .WB_ADR_I(WB_ADR_I),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_WE_I(WB_WE_I),
        .WB_SEL_I(WB_SEL_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_ACK_O(WB_ACK_O), .STANDBY_PIN_N(STANDBY_PIN_N),
        .RESET_PIN_N(RESET_PIN_N), .SLEEP_EXEC(SLEEP_EXEC),
        .IRQ_ACCEPT(IRQ_ACCEPT), .MEDIUM_REQ(MEDIUM_REQ),
        .PERIPH_CLK_EN(PERIPH_CLK_EN), .MODE(MODE),
        .MAIN_CLK_RUN(obs[8]), .SUB_CLK_RUN(obs[7]), .CPU_RUN(obs[6]),
        .CPU_ON_SUB(obs[5]), .CPU_REGS_KEEP(obs[4]), .EXT_IRQ_EN(obs[3]),
        .WDT_RUN(obs[2]), .WDT_ON_SUB(obs[1]), .WDT_CLEAR(obs[0])
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] got,
                       input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Classic single cycle; no cycle count assumed, bounded wait only
    task automatic wb(input logic [4:0] a, input logic we,
                      input logic [3:0] sel, input logic [7:0] d);
        int n;
        @(posedge CLK_SYS);
        WB_ADR_I <= a;
        WB_WE_I  <= we;
        WB_SEL_I <= sel;
        WB_DAT_I <= {24'h0, d};
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (WB_ACK_O !== 1'b1 && n < 20);
        rd = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            summarize();
        end
    endtask

    // Expected unit states per mode, straight from the state table
    function automatic logic [8:0] exp_dec(input logic [3:0] m);
        case (m)
            MSC_HIGH, MSC_MEDIUM: return 9'b111011100;
            MSC_SLEEP:            return 9'b110011100;
            MSC_WATCH, MSC_SUBSLP: return 9'b010011110;
            MSC_SUBACT:           return 9'b011111110;
            MSC_SWSBY:            return 9'b000011000;
            MSC_RESET:            return 9'b110000001;
            default:              return 9'b000000001;
        endcase
    endfunction

    // Enable 15 follows the transfer controller bit, 14..0 their own bits
    function automatic logic [15:0] exp_en(input logic run);
        return run ? {~stop16[14], ~stop16[14:0]} : 16'h0;
    endfunction

    task automatic chk_mode(input logic [3:0] m);
        logic [8:0] e;
        e = exp_dec(m);
        chk("mode", MODE, m);
        chk("unit_state", obs, e);
        chk("clk_en", PERIPH_CLK_EN, exp_en(e[8]));
    endtask

    // k 0 sleep, 1 irq, 2 medium level, 3 standby pin, 4 reset pin
    task automatic ev_step(input int k, input logic v, input logic [3:0] m);
        @(posedge CLK_SYS);
        case (k)
            0: SLEEP_EXEC <= 1'b1;
            1: IRQ_ACCEPT <= 1'b1;
            2: MEDIUM_REQ <= v;
            3: STANDBY_PIN_N <= v;
            default: RESET_PIN_N <= v;
        endcase
        @(posedge CLK_SYS);
        SLEEP_EXEC <= 1'b0;
        IRQ_ACCEPT <= 1'b0;
        @(negedge CLK_SYS);
        chk_mode(m);
    endtask

    task automatic set_cfg(input logic [7:0] c);
        wb({PAGE_MODE[0], ADR_MODE_CFG}, 1'b1, 4'hF, c);
    endtask

    initial begin
        logic [4:0] adr [4];
        logic [7:0] f0 [4];
        logic [7:0] f1 [4];
        logic [7:0] rv [4];
        logic [7:0] cur [4];
        adr = '{ADR_MAIN_HI, ADR_MAIN_LO, ADR_SUB_HI, ADR_SUB_LO};
        f0 = '{FIX0_MAIN_HI, 8'h00, 8'h00, 8'h00};
        f1 = '{8'h00, FIX1_MAIN_LO, FIX1_SUB_HI, FIX1_SUB_LO};
        rv = '{RST_MAIN_HI, RST_MAIN_LO, RST_SUB_HI, RST_SUB_LO};
        stop16 = {RST_MAIN_HI, RST_MAIN_LO};
        repeat (6) @(posedge CLK_SYS);
        RST <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        chk_mode(MSC_HIGH);
        for (int i = 0; i < 4; i++) begin
            wb(adr[i], 1'b0, 4'hF, 8'h00);
            chk("reset_value", rd, {24'h0, rv[i]});
            cur[i] = rv[i];
        end
        $display("test reset_values done");
        // Random and corner writes; fixed bits must hold their level
        for (int t = 0; t < 24; t++) begin
            int i;
            i = t % 4;
            wv = (t < 4) ? 8'hFF : (t < 8) ? 8'h00 : 8'($random(seed));
            ev = (wv & ~f0[i]) | f1[i];
            wb(adr[i], 1'b1, 4'hF, wv);
            wb(adr[i], 1'b0, 4'hF, 8'h00);
            chk("stop_reg", rd, {24'h0, ev});
            cur[i] = ev;
            stop16 = {cur[0], cur[1]};
            @(negedge CLK_SYS);
            chk("clk_en", PERIPH_CLK_EN, exp_en(1'b1));
        end
        wb(ADR_MAIN_LO, 1'b1, 4'hE, ~cur[1]);
        wb(ADR_MAIN_LO, 1'b0, 4'hF, 8'h00);
        chk("no_lane_write", rd, {24'h0, cur[1]});
        wb(5'h1C, 1'b1, 4'hF, 8'h5A);
        wb(5'h1C, 1'b0, 4'hF, 8'h00);
        chk("unmapped", rd, 32'h0);
        $display("test stop_registers done");
        set_cfg(8'h00);
        ev_step(0, 1'b1, MSC_SLEEP);
        ev_step(1, 1'b1, MSC_HIGH);
        ev_step(2, 1'b1, MSC_MEDIUM);
        ev_step(0, 1'b1, MSC_SLEEP);
        ev_step(1, 1'b1, MSC_MEDIUM);
        ev_step(2, 1'b0, MSC_HIGH);
        set_cfg(8'h01);
        ev_step(0, 1'b1, MSC_SWSBY);
        ev_step(1, 1'b1, MSC_HIGH);
        set_cfg(8'h07);
        ev_step(0, 1'b1, MSC_WATCH);
        ev_step(1, 1'b1, MSC_SUBACT);
        set_cfg(8'h00);
        ev_step(0, 1'b1, MSC_SUBSLP);
        ev_step(1, 1'b1, MSC_SUBACT);
        $display("test mode_walk done");
        ev_step(4, 1'b0, MSC_RESET);
        ev_step(3, 1'b0, MSC_HWSBY);
        ev_step(4, 1'b1, MSC_HWSBY);
        ev_step(4, 1'b0, MSC_HWSBY);
        ev_step(3, 1'b1, MSC_RESET);
        ev_step(4, 1'b1, MSC_HIGH);
        ev_step(3, 1'b0, MSC_HWSBY);
        ev_step(3, 1'b1, MSC_RESET);
        @(negedge CLK_SYS);
        chk_mode(MSC_HIGH);
        $display("test pins done");
        summarize();
    end
endmodule
